// [logic/bmsl_pkg.sv]
/*
  shared constants, register map and setting types of the boot mode stream loader.
  assumes a 50 MHz apb clock and a serial mode source clocked by our divided clock.
*/
// Functional notes
// RQ1: stream moves one bit per serial clock period, bus clock divided by 256.
// RQ2: settings are captured only during the init sequence, then stay fixed; the code keeps the short-multiply bit writable over apb.
// RQ3: source drives zero in reserved positions 0, 18, 20-24, 27 onward.
// RQ4: bits 1-4 pick transmit pattern, bit 4 msb; codes 9-15 never sent.
// RQ5: multiplier field codes 0-6 give ratios 2 to 8; code 7 reserved.
// RQ6: bit 8 low means little-endian, high means big-endian.
// RQ7: bits 10:9 pick write protocol: legacy, reserved, pipelined, reissue.
// RQ8: bit 11 low routes timer interrupt to input five, high cuts it.
// RQ9: bit 12 low selects 64-bit interface, high selects 32-bit.
// RQ10: 32-bit mode uses four check bits instead of eight.
// RQ11: bits 15-17 give 0 to 7 idle cycles between write address and data.
// RQ12: delay applies to all writes; code zero keeps legacy timing.
// RQ13: bit 19 is initial short-multiply setting; low enables it.
// RQ14: above 250 MHz pipeline, source must set bit 19.
// RQ15: short multiply disabled adds one cycle latency and repeat.
// RQ16: bits 25,26 sent as zero, copied to setup register bits 21:20.
// RQ17: source may be serial memory or glue logic making the bits.
// RQ18: stream sent in ascending order from position zero.
`default_nettype none
package bmsl_pkg;
  localparam int STREAM_BITS = 256;
  localparam int KEEP_BITS = 27;
  localparam int DIV_RATIO = 256;
  localparam logic [7:0] DIV_SAMPLE = 8'hff;
  // stream positions
  localparam int POS_TXPAT = 1;
  localparam int POS_RATIO = 5;
  localparam int POS_ENDIAN = 8;
  localparam int POS_NBWR = 9;
  localparam int POS_TIMER = 11;
  localparam int POS_WIDTH = 12;
  localparam int POS_WDELAY = 15;
  localparam int POS_FASTMUL = 19;
  localparam int POS_IDENT = 25;
  localparam logic [26:0] RSV_MASK = 27'h7f4_0001;
  localparam logic [3:0] TXPAT_MAX = 4'h8;
  localparam logic [2:0] RATIO_RSV = 3'h7;
  localparam logic [1:0] NBWR_RSV = 2'h1;
  localparam logic [3:0] RATIO_BASE = 4'h2;
  localparam logic [7:0] CHK_64 = 8'hff;
  localparam logic [7:0] CHK_32 = 8'h0f;
  // apb map
  localparam logic [11:0] OFS_STATUS = 12'h000;
  localparam logic [11:0] OFS_SETUP = 12'h004;
  localparam logic [11:0] OFS_STREAM = 12'h008;
  // setup register fields
  localparam int SU_RATIO = 0;
  localparam int SU_ENDIAN = 3;
  localparam int SU_NBWR = 4;
  localparam int SU_TIMER = 6;
  localparam int SU_WIDTH = 7;
  localparam int SU_WDELAY = 8;
  localparam int SU_FASTMUL = 11;
  localparam int SU_TXPAT = 12;
  localparam int SU_IDENT = 20;

  typedef enum logic [1:0] {
    BMSL_NB_LEGACY = 2'h0,
    BMSL_NB_RSV = 2'h1,
    BMSL_NB_PIPE = 2'h2,
    BMSL_NB_REISSUE = 2'h3
  } bmsl_nbwr_t;

  typedef struct packed {
    logic [3:0] tx_pattern;
    logic [2:0] ratio_code;
    logic big_endian;
    bmsl_nbwr_t nb_write;
    logic timer_irq_route_off;
    logic bus_32bit;
    logic [2:0] write_gap;
    logic fast_mul_off;
    logic [1:0] sys_ident;
  } bmsl_cfg_t;

  typedef struct packed {
    logic [3:0] pipe_ratio;
    logic [7:0] check_bits_en;
    logic mul_extra_cycle;
  } bmsl_core_t;
endpackage
`default_nettype wire

// [logic/bmsl_stream_rx.sv]
/*
  serial mode stream receiver: divides pclk by the ratio, drives the serial
  clock and shifts the incoming bits in ascending order.
  assumes the source changes its bit on the rising serial clock edge.
*/
`default_nettype none
module bmsl_stream_rx
  import bmsl_pkg::*;
#(
  parameter int NBITS = STREAM_BITS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic mode_din,
  output logic mode_clk,
  output logic [KEEP_BITS-1:0] bits,
  output logic done
);
  logic [7:0] div;
  logic [2:0] sync;
  logic [8:0] count;
  logic sample;
  logic last;

  // clock high in the first half of each period
  assign mode_clk = run & ~div[7]; // [RQ1]
  assign sample = run && (div == DIV_SAMPLE) && (sync[2] == sync[1]);
  assign last = (count == 9'(NBITS - 1));

  // divider and three-stage pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= 8'h00;
      sync <= 3'h0;
    end else begin
      div <= run ? div + 8'h01 : 8'h00; // [RQ1]
      sync <= {sync[1:0], mode_din};
    end
  end

  // late-period sample lets the bit settle well before capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 9'h000;
      bits <= '0;
      done <= 1'b0;
    end else if (sample) begin
      if (count < 9'(KEEP_BITS))
        bits[count[4:0]] <= sync[2]; // [RQ18]
      count <= count + 9'h001;
      done <= last;
    end
  end
endmodule
`default_nettype wire

// [logic/bmsl_top.sv]
/*
  boot mode stream loader: loads the serial mode stream after reset, holds the
  core in init while loading, then presents settings, fixed but for the short-multiply bit, and an apb view.
  the settings have no reload path: a new stream needs a new reset.
  assumes a zero-wait apb master on pclk and a core that waits on init_busy.
  assumes timer_tick and wr_addr_sent come from logic on pclk, so they are
  used without synchronisers; only mode_din is a pin.
*/
`default_nettype none
module bmsl_top (
  input wire logic pclk,
  input wire logic presetn,
  // register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial mode link
  input wire logic mode_din,
  output logic mode_clk,
  // settings handed to the core
  output logic init_busy,
  output bmsl_pkg::bmsl_cfg_t cfg,
  output bmsl_pkg::bmsl_core_t core,
  // timer routing and write timing
  input wire logic timer_tick,
  output logic int5_timer_req,
  input wire logic wr_addr_sent,
  output logic wr_data_go
);
  import bmsl_pkg::*;

  // receiver and load state
  logic [KEEP_BITS-1:0] bits;
  logic rx_done;
  logic loaded;
  bmsl_cfg_t next_cfg;

  // reserved-code checks on the raw stream
  logic rsv_set;
  logic txpat_bad;
  logic ratio_bad;
  logic nbwr_bad;
  logic bad_code;

  // write gap counter
  logic [2:0] gap_cnt;
  logic [2:0] gap_next;
  logic gap_run;
  logic gap_start;
  logic gap_none;
  logic gap_end;

  // apb decode and read views
  logic [31:0] setup_word;
  logic [31:0] status_word;
  logic [31:0] next_prdata;
  logic apb_acc;
  logic hit_status;
  logic hit_setup;
  logic hit_stream;
  logic hit_any;
  logic setup_wr;
  logic rd_capture;
  logic next_fast_mul_off;

  // core-facing next values
  bmsl_core_t next_core;
  logic next_int5;

  // one offset compare, shared by every register decode
  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ofs);
    return a == ofs;
  endfunction

  // receiver runs only until the stream is in
  // run drops once loaded, which parks mode_clk low
  bmsl_stream_rx #(
    .NBITS(STREAM_BITS)
  ) u_rx (
    .pclk(pclk),
    .presetn(presetn),
    .run(~loaded),
    .mode_din(mode_din),
    .mode_clk(mode_clk),
    .bits(bits),
    .done(rx_done)
  );

  // decode of the raw stream into settings
  // field positions follow the stream, lowest position first
  assign next_cfg.tx_pattern = bits[POS_TXPAT +: 4]; // [RQ4]
  assign next_cfg.ratio_code = bits[POS_RATIO +: 3]; // [RQ5]
  assign next_cfg.big_endian = bits[POS_ENDIAN]; // [RQ6]
  assign next_cfg.nb_write = bmsl_nbwr_t'(bits[POS_NBWR +: 2]); // [RQ7]
  assign next_cfg.timer_irq_route_off = bits[POS_TIMER]; // [RQ8]
  assign next_cfg.bus_32bit = bits[POS_WIDTH]; // [RQ9]
  assign next_cfg.write_gap = bits[POS_WDELAY +: 3]; // [RQ11]
  assign next_cfg.fast_mul_off = bits[POS_FASTMUL]; // [RQ13]
  assign next_cfg.sys_ident = bits[POS_IDENT +: 2]; // [RQ16]

  // reserved codes are reported, not corrected; the source owns them
  assign rsv_set = |(bits & RSV_MASK);
  assign txpat_bad = (next_cfg.tx_pattern > TXPAT_MAX);
  assign ratio_bad = (next_cfg.ratio_code == RATIO_RSV);
  assign nbwr_bad = (next_cfg.nb_write == BMSL_NB_RSV);
  // one flag for all; software reads the raw stream to see which field
  assign bad_code = rsv_set | txpat_bad | ratio_bad | nbwr_bad;

  // apb decode; zero wait states
  assign apb_acc = psel & penable;
  assign hit_status = addr_is(paddr, OFS_STATUS);
  assign hit_setup = addr_is(paddr, OFS_SETUP);
  assign hit_stream = addr_is(paddr, OFS_STREAM);
  assign hit_any = hit_status | hit_setup | hit_stream;
  assign pready = 1'b1;
  assign pslverr = apb_acc & ~hit_any;
  assign setup_wr = apb_acc & pwrite & hit_setup & loaded;
  assign rd_capture = psel & ~penable & ~pwrite;
  assign next_fast_mul_off = pwdata[SU_FASTMUL];

  // software view of the settings
  always_comb begin
    setup_word = 32'h0000_0000;
    setup_word[SU_RATIO +: 3] = cfg.ratio_code;
    setup_word[SU_ENDIAN] = cfg.big_endian;
    setup_word[SU_NBWR +: 2] = cfg.nb_write;
    setup_word[SU_TIMER] = cfg.timer_irq_route_off;
    setup_word[SU_WIDTH] = cfg.bus_32bit;
    setup_word[SU_WDELAY +: 3] = cfg.write_gap;
    setup_word[SU_FASTMUL] = cfg.fast_mul_off;
    setup_word[SU_TXPAT +: 4] = cfg.tx_pattern;
    setup_word[SU_IDENT +: 2] = cfg.sys_ident; // [RQ16]
  end

  // status: gap counting, reserved code seen, loaded
  assign status_word = {29'h0000_0000, gap_run, bad_code & loaded, loaded};

  // read mux; unmapped offsets read zero
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (hit_status)
      next_prdata = status_word;
    else if (hit_setup)
      next_prdata = setup_word;
    else if (hit_stream)
      next_prdata = {5'h00, bits};
  end

  // read data registered at the setup phase, stable through the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (rd_capture)
      prdata <= next_prdata;
  end

  // settings latch once; only the short-multiply bit stays writable
  // load wins; a setup write cannot meet it since writes wait for load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loaded <= 1'b0;
      cfg <= '0;
    end else if (!loaded && rx_done) begin
      loaded <= 1'b1; // [RQ2]
      cfg <= next_cfg; // [RQ2]
    end else if (setup_wr) begin
      cfg.fast_mul_off <= next_fast_mul_off; // [RQ13]
    end
  end

  // core held in init until the stream is in
  assign init_busy = ~loaded; // [RQ2]

  // settings as the core consumes them; registered so the core sees clean levels
  assign next_core.pipe_ratio = {1'b0, cfg.ratio_code} + RATIO_BASE; // [RQ5]
  assign next_core.check_bits_en = cfg.bus_32bit ? CHK_32 : CHK_64; // [RQ10]
  assign next_core.mul_extra_cycle = cfg.fast_mul_off; // [RQ15]
  // timer pulses pass only once loaded and while routed to input five
  assign next_int5 = loaded & timer_tick & ~cfg.timer_irq_route_off; // [RQ8]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core <= '0;
      int5_timer_req <= 1'b0;
    end else begin
      core <= next_core;
      int5_timer_req <= next_int5;
    end
  end

  // idle cycles between write address and write data; an address that comes
  // while counting is ignored, so the requester must wait for wr_data_go
  assign gap_start = wr_addr_sent && loaded && !gap_run;
  assign gap_none = (cfg.write_gap == 3'h0);
  assign gap_next = gap_cnt + 3'h1;
  assign gap_end = gap_run && (gap_next == cfg.write_gap);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_run <= 1'b0;
      gap_cnt <= 3'h0;
      wr_data_go <= 1'b0;
    end else begin
      wr_data_go <= 1'b0;
      if (gap_start) begin
        gap_cnt <= 3'h0;
        if (gap_none)
          wr_data_go <= 1'b1; // [RQ12]
        else
          gap_run <= 1'b1; // [RQ11]
      end else if (gap_run) begin
        gap_cnt <= gap_next;
        if (gap_end) begin
          gap_run <= 1'b0;
          wr_data_go <= 1'b1; // [RQ11]
        end
      end
    end
  end

endmodule
`default_nettype wire

// [test/bmsl_asserts.sv]
/* port checks of the mode stream loader.
   assumes one pclk domain and presetn active low. */
`default_nettype none
module bmsl_asserts
  import bmsl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mode_clk,
  input wire logic init_busy,
  input wire bmsl_pkg::bmsl_cfg_t cfg,
  input wire bmsl_pkg::bmsl_core_t core,
  input wire logic timer_tick,
  input wire logic int5_timer_req,
  input wire logic wr_addr_sent,
  input wire logic wr_data_go
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // core view trails the settings by a cycle
  ratio_map_a: assert property ($past(presetn) |->
    core.pipe_ratio == $past(cfg.ratio_code) + 4'h2) else $error("bad ratio");
  check_bits_a: assert property ($past(presetn) |->
    core.check_bits_en == ($past(cfg.bus_32bit) ? CHK_32 : CHK_64)) else $error("bad check");
  mul_extra_a: assert property ($past(presetn) |->
    core.mul_extra_cycle == $past(cfg.fast_mul_off)) else $error("bad mul");
  timer_route_a: assert property (!init_busy && timer_tick |=>
    int5_timer_req == !$past(cfg.timer_irq_route_off)) else $error("bad timer");
  write_gap_a: assert property (wr_data_go && cfg.write_gap == 3'h2 |->
    $past(wr_addr_sent, 3)) else $error("bad gap");
  // ratio, width and pattern settings must not drift once loaded
  cfg_fixed_a: assert property (!init_busy && !$past(init_busy) |->
    $stable(cfg.ratio_code) && $stable(cfg.bus_32bit) && $stable(cfg.tx_pattern))
    else $error("cfg moved");
  clk_period_a: assert property ($fell(mode_clk) ##128 init_busy |-> $rose(mode_clk))
    else $error("bad serial clock");
  clk_idle_a: assert property (!init_busy |-> !mode_clk)
    else $error("serial clock runs");
  cover property ($fell(init_busy));
  cover property (wr_data_go);
  cover property (int5_timer_req);
endmodule
bind bmsl_top bmsl_asserts CHK (.pclk, .presetn, .mode_clk, .init_busy, .cfg, .core,
  .timer_tick, .int5_timer_req, .wr_addr_sent, .wr_data_go);
`default_nettype wire

// [test/bmsl_src.sv]
/* serial mode source model: shifts a fixed word out.
   assumes mode_clk stands high out of reset with position 0 already on the pin,
   and each later rise of mode_clk moves one position on. */
`default_nettype none
module bmsl_src
  import bmsl_pkg::*;
(
  input wire logic mode_clk,
  input wire logic presetn,
  input wire logic [KEEP_BITS-1:0] word,
  output logic mode_din
);
  timeunit 1ns;
  timeprecision 1ns;
  int pos;
  // new bit on each rising serial clock, ascending
  always @(posedge mode_clk or negedge presetn) begin
    if (!presetn) pos <= 0;
    else pos <= pos + 1;
  end
  // zero outside the meaningful positions
  assign mode_din = (pos >= 0 && pos < KEEP_BITS) ? word[pos] : 1'b0;
endmodule
`default_nettype wire

// [test/bmsl_top_test.sv]
/* self-checking bench of the mode stream loader.
   assumes the checker and source model are compiled first. */
`default_nettype none
module bmsl_top_test;
  import bmsl_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // pattern 5, ratio 3, big, pipelined, 32-bit, gap 2, fast off
  localparam logic [26:0] WORD = 27'h009_156a;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic timer_tick = 0, wr_addr_sent = 0;
  logic [1:0] tk = 2'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [31:0] rs = 32'd98;
  logic pready, pslverr, mode_din, mode_clk, init_busy, int5_timer_req, wr_data_go;
  bmsl_cfg_t cfg;
  bmsl_core_t core;
  logic [32:0] expq[$];
  int miscompares = 0, comparisons = 0, n;
  initial forever #10 pclk = ~pclk;
  bmsl_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .mode_din, .mode_clk, .init_busy, .cfg, .core, .timer_tick,
    .int5_timer_req, .wr_addr_sent, .wr_data_go);
  bmsl_src SRC (.mode_clk, .presetn, .word(WORD), .mode_din);
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    if (miscompares == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // one apb transfer; reads note {pslverr, prdata} expected
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      input logic [32:0] e);
    if (!wr) expq.push_back(e);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    for (n = 0; pready !== 1'b1 && n < 50; n++) @(posedge pclk);
    if (n == 50) begin
      miscompares++;
      finish_test;
    end
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  // read results compared at the completing edge
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && expq.size() > 0)
      check({pslverr, prdata}, expq.pop_front());
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    for (n = 0; init_busy !== 1'b0 && n < 70000; n++) @(posedge pclk);
    if (n == 70000) begin
      miscompares++;
      finish_test;
    end
    repeat (2) @(posedge pclk);
    check(cfg, {4'h5, 3'h3, 1'b1, 2'h2, 1'b0, 1'b1, 3'h2, 1'b1, 2'h0});
    check(core, {4'h5, 8'h0f, 1'b1});
    apb(0, OFS_SETUP, 0, {1'b0, 32'h0000_5aab});
    apb(0, OFS_STREAM, 0, {6'h0, WORD});
    apb(0, OFS_STATUS, 0, 33'h1);
    apb(0, 12'h00c, 0, 33'h1_0000_0000);
    rs = xs(rs);
    apb(1, OFS_SETUP, rs & ~32'h800, 0);
    apb(0, OFS_SETUP, 0, {1'b0, 32'h0000_52ab});
    // random ticks exercise the timer routing
    repeat (20) begin
      rs = xs(rs);
      check(33'(int5_timer_req), 33'(tk[1]));
      tk = {tk[0], rs[0]};
      timer_tick <= rs[0];
      @(posedge pclk);
    end
    timer_tick <= 0;
    wr_addr_sent <= 1;
    @(posedge pclk);
    wr_addr_sent <= 0;
    for (n = 0; wr_data_go !== 1'b1 && n < 20; n++) @(posedge pclk);
    check(33'(n), 33'h3);
    finish_test;
  end
endmodule
`default_nettype wire
